// ===== rtl/gio_axis_capture.sv
// one joystick axis: pin synchroniser and count capture
`timescale 1ns/1ns
module gio_axis_capture #(
  parameter int CNT_W = 15
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // monostable pin and running count
  input wire logic pulse_i,
  input wire logic [CNT_W-1:0] count_i,
  // captured count
  output logic [CNT_W-1:0] count_o
);
  logic s1_reg, s2_reg, s3_reg;
  logic [CNT_W-1:0] cap_reg, cap_next;
  logic fall;

  // capture on return to the stable low level
  assign fall = s3_reg & ~s2_reg;
  always_comb begin
    cap_next = cap_reg;
    if (fall) begin
      cap_next = count_i; // R3
    end
  end

  // registers, s1 feeds only s2
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      cap_reg <= '0;
    end else begin
      s1_reg <= pulse_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      cap_reg <= cap_next;
    end
  end
  assign count_o = cap_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_axis_capture: assert property ( // R3
    fall |=> count_o == $past(count_i))
    else $error("axis count not captured at pulse end");
endmodule : gio_axis_capture

// ===== rtl/gio_pkg.sv
// constants for the game io peripheral block
// Operation
// (R1) 15-bit counter advances on 1 MHz tick, wraps
// (R2) rollover latches buttons and fires all triggers
// (R3) each axis captures count when monostable ends
// (R4) axis read returns top eight count bits
// (R5) button read returns buttons in bits 0..3
// (R6) button bit zero means button was pressed
// (R7) ports 0..3 axes, port 4 buttons
// (R8) port 6 serial data, port 7 status
// (R9) data write transmits, data read returns received
// (R10) status shows transmitter ready and receive waiting
// (R11) any status write clears received flag; the code keeps it set when a byte arrives in the same cycle
// (R12) full duplex serial, no flow control lines
// (R13) serial rate fixed at 9600 bits/s
// (R14) ports 8..11 write lamp and segment bytes
// (R15) four bytes drive 16 lamps, four digits
// (R16) unassigned ports read zero, ignore writes
// (R17) status bit 0 tx ready, bit 1 rx
// (R18) read: data presented while strobe high, direction low
// (R19) write: data taken at edge, direction high
// (R20) 4-bit port, separate 8-bit data paths
package gio_pkg;
  // ---------------
  // bus shape
  // ---------------
  localparam int PORT_W = 4;
  localparam int DATA_W = 8;
  localparam int CNT_W = 15;
  localparam int AXES = 4;
  localparam int BUTTONS = 4;
  localparam int LAMPS = 16;
  // ---------------
  // port map
  // ---------------
  localparam logic [PORT_W-1:0] PORT_STICK1_X = 4'h0;
  localparam logic [PORT_W-1:0] PORT_STICK1_Y = 4'h1;
  localparam logic [PORT_W-1:0] PORT_STICK2_X = 4'h2;
  localparam logic [PORT_W-1:0] PORT_STICK2_Y = 4'h3;
  localparam logic [PORT_W-1:0] PORT_BUTTONS = 4'h4;
  localparam logic [PORT_W-1:0] PORT_SER_DATA = 4'h6;
  localparam logic [PORT_W-1:0] PORT_SER_STATUS = 4'h7;
  localparam logic [PORT_W-1:0] PORT_LAMP_LO = 4'h8;
  localparam logic [PORT_W-1:0] PORT_LAMP_HI = 4'h9;
  localparam logic [PORT_W-1:0] PORT_SEG_LO = 4'ha;
  localparam logic [PORT_W-1:0] PORT_SEG_HI = 4'hb;
  // ---------------
  // fields and reset values
  // ---------------
  localparam int STAT_TX_READY_BIT = 0;
  localparam int STAT_RX_FULL_BIT = 1;
  localparam int AXIS_TOP_LSB = 7;
  localparam logic [BUTTONS-1:0] BUTTON_RST = 4'hf;
  localparam logic [LAMPS-1:0] LAMP_RST = 16'h0000;
  localparam logic [LAMPS-1:0] SEG_RST = 16'h0000;
  localparam logic [CNT_W-1:0] COUNT_RST = 15'h0000;
  // ---------------
  // timing
  // ---------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_NS = 1000;
  localparam int TICK_DIV = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICK_W = $clog2(TICK_DIV);
  localparam int BAUD_BPS = 9600;
  localparam int BIT_TIME_NS = 1000000000 / BAUD_BPS;
  localparam int BAUD_DIV = BIT_TIME_NS / CLK_PERIOD_NS;
endpackage : gio_pkg

// ===== rtl/gio_top.sv
// game io peripherals: port decoder, joystick, serial, lamps
`timescale 1ns/1ns
module gio_top #(
  parameter int BAUD_DIV = gio_pkg::BAUD_DIV,
  parameter int TICK_CLKS = gio_pkg::TICK_DIV
) (
  // clock and reset
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  // peripheral bus from the cpu
  input wire logic [gio_pkg::PORT_W-1:0] PORT_SELECT_I,
  input wire logic BUS_DIRECTION_I,
  input wire logic BUS_TRANSFER_STROBE_I,
  input wire logic [gio_pkg::DATA_W-1:0] BUS_WRITE_DATA_I,
  output logic [gio_pkg::DATA_W-1:0] BUS_READ_DATA_O,
  // joystick pins
  input wire logic [gio_pkg::AXES-1:0] STICK_AXIS_I,
  input wire logic [gio_pkg::BUTTONS-1:0] STICK_BUTTON_N_I,
  output logic STICK_TRIGGER_O,
  // serial pins
  input wire logic UART_RX_I,
  output logic UART_TX_O,
  // lamps and seven segment digits
  output logic [gio_pkg::LAMPS-1:0] LAMP_O,
  output logic [gio_pkg::LAMPS-1:0] SEGMENT_O
);
  import gio_pkg::*;

  // ---------------
  // declarations
  // ---------------
  logic rd_en;
  logic wr_en;
  logic tick;
  logic rollover;
  localparam int TICK_CW = $clog2(TICK_CLKS + 1);
  logic [TICK_CW-1:0] tick_cnt_reg, tick_cnt_next;
  logic [CNT_W-1:0] count_reg, count_next;
  logic trig_reg, trig_next;
  logic [BUTTONS-1:0] btn_s1_reg, btn_s2_reg;
  logic [BUTTONS-1:0] button_reg, button_next;
  logic [CNT_W-1:0] axis_cnt [AXES];
  logic tx_start;
  logic tx_ready;
  logic rx_valid;
  logic [7:0] rx_data;
  logic rx_full_reg, rx_full_next;
  logic [LAMPS-1:0] lamp_reg, lamp_next;
  logic [LAMPS-1:0] seg_reg, seg_next;
  logic [DATA_W-1:0] rd_data;

  // ---------------
  // bus strobes
  // ---------------
  // direction low reads, high writes
  assign rd_en = BUS_TRANSFER_STROBE_I & ~BUS_DIRECTION_I; // R18
  assign wr_en = BUS_TRANSFER_STROBE_I & BUS_DIRECTION_I; // R19

  // ---------------
  // 1 MHz tick
  // ---------------
  assign tick = (tick_cnt_reg == TICK_CW'(TICK_CLKS - 1));

  // divide the reference clock down to the tick
  always_comb begin
    if (tick) begin
      tick_cnt_next = '0;
    end else begin
      tick_cnt_next = tick_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
    end
  end

  // ---------------
  // joystick sampling counter
  // ---------------
  assign rollover = tick && (count_reg == '1);

  // free running count, wraps to zero after all ones
  always_comb begin
    count_next = count_reg;
    if (tick) begin
      count_next = count_reg + 15'h0001; // R1
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      count_reg <= COUNT_RST;
    end else begin
      count_reg <= count_next;
    end
  end

  // ---------------
  // buttons and trigger
  // ---------------
  // trigger held for one tick after each rollover
  always_comb begin
    trig_next = trig_reg;
    button_next = button_reg;
    if (rollover) begin
      trig_next = 1'b1; // R2
      button_next = btn_s2_reg; // R2 R6
    end else if (tick) begin
      trig_next = 1'b0;
    end
  end

  // button pins pass two flops before the latch
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      btn_s1_reg <= BUTTON_RST;
      btn_s2_reg <= BUTTON_RST;
      button_reg <= BUTTON_RST;
      trig_reg <= 1'b0;
    end else begin
      btn_s1_reg <= STICK_BUTTON_N_I;
      btn_s2_reg <= btn_s1_reg;
      button_reg <= button_next;
      trig_reg <= trig_next;
    end
  end
  assign STICK_TRIGGER_O = trig_reg;

  // ---------------
  // axis capture
  // ---------------
  // one capture unit per axis
  for (genvar g = 0; g < AXES; g++) begin : g_axis
    gio_axis_capture #(
      .CNT_W(CNT_W)
    ) u_axis (
      .clk_i(REF_CLK_I),
      .rst_i(RST_I),
      .pulse_i(STICK_AXIS_I[g]),
      .count_i(count_reg),
      .count_o(axis_cnt[g])
    );
  end

  // ---------------
  // serial port
  // ---------------
  // a data write starts a byte when the transmitter is free
  assign tx_start = wr_en && (PORT_SELECT_I == PORT_SER_DATA); // R9

  gio_uart #(
    .CLK_DIV(BAUD_DIV)
  ) u_uart (
    .clk_i(REF_CLK_I),
    .rst_i(RST_I),
    .tx_start_i(tx_start),
    .tx_data_i(BUS_WRITE_DATA_I),
    .tx_ready_o(tx_ready),
    .tx_pin_o(UART_TX_O),
    .rx_pin_i(UART_RX_I),
    .rx_valid_o(rx_valid),
    .rx_data_o(rx_data)
  );

  // received flag, a new byte wins over a clear
  always_comb begin
    rx_full_next = rx_full_reg;
    if (wr_en && PORT_SELECT_I == PORT_SER_STATUS) begin
      rx_full_next = 1'b0; // R11
    end
    if (rx_valid) begin
      rx_full_next = 1'b1;
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rx_full_reg <= 1'b0;
    end else begin
      rx_full_reg <= rx_full_next;
    end
  end

  // ---------------
  // lamps and digits
  // ---------------
  // write only bytes, unassigned ports change nothing
  always_comb begin
    lamp_next = lamp_reg;
    seg_next = seg_reg;
    if (wr_en) begin
      case (PORT_SELECT_I)
        PORT_LAMP_LO: lamp_next[7:0] = BUS_WRITE_DATA_I; // R14
        PORT_LAMP_HI: lamp_next[15:8] = BUS_WRITE_DATA_I; // R14
        PORT_SEG_LO: seg_next[7:0] = BUS_WRITE_DATA_I; // R14
        PORT_SEG_HI: seg_next[15:8] = BUS_WRITE_DATA_I; // R14
        default: begin
          lamp_next = lamp_reg; // R16
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      lamp_reg <= LAMP_RST;
      seg_reg <= SEG_RST;
    end else begin
      lamp_reg <= lamp_next;
      seg_reg <= seg_next;
    end
  end
  assign LAMP_O = lamp_reg; // R15
  assign SEGMENT_O = seg_reg; // R15

  // ---------------
  // read data mux
  // ---------------
  // selects a registered value, zero when not reading
  always_comb begin
    rd_data = 8'h00;
    if (rd_en) begin
      case (PORT_SELECT_I)
        PORT_STICK1_X, PORT_STICK1_Y, PORT_STICK2_X, PORT_STICK2_Y: begin
          rd_data = axis_cnt[PORT_SELECT_I[1:0]][CNT_W-1:AXIS_TOP_LSB];
        end
        PORT_BUTTONS: rd_data = {4'h0, button_reg}; // R5
        PORT_SER_DATA: rd_data = rx_data; // R9
        PORT_SER_STATUS: begin
          rd_data[STAT_TX_READY_BIT] = tx_ready; // R10 R17
          rd_data[STAT_RX_FULL_BIT] = rx_full_reg; // R10 R17
        end
        default: rd_data = 8'h00; // R16
      endcase
    end
  end
  assign BUS_READ_DATA_O = rd_data; // R4 R7 R8 R20

  // ---------------
  // checks
  // ---------------
  localparam int TICK_GAP = TICK_CLKS;

  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);

  sequence s_rollover;
    tick && (count_reg == '1);
  endsequence

  sequence s_trig_window;
    trig_reg ##TICK_GAP !trig_reg;
  endsequence

  chk_tick_period: assert property ( // R1
    tick |-> ##TICK_GAP tick)
    else $error("tick period wrong");

  chk_count_step: assert property ( // R1
    tick |=> count_reg == 15'($past(count_reg) + 15'h0001))
    else $error("counter did not advance on tick");

  chk_rollover_latch: assert property ( // R2 R6
    s_rollover |=> trig_reg && (button_reg == $past(btn_s2_reg)))
    else $error("rollover did not latch buttons or trigger");

  chk_trigger_width: assert property ( // R2
    s_rollover |=> s_trig_window)
    else $error("trigger pulse not one tick long");

  chk_axis_read: assert property ( // R4 R7
    rd_en && PORT_SELECT_I == PORT_STICK2_Y |->
      BUS_READ_DATA_O == axis_cnt[3][CNT_W-1:AXIS_TOP_LSB])
    else $error("axis read returned wrong bits");

  chk_button_read: assert property ( // R5
    rd_en && PORT_SELECT_I == PORT_BUTTONS |->
      BUS_READ_DATA_O == {4'h0, button_reg})
    else $error("button read wrong");

  chk_status_read: assert property ( // R10 R17
    rd_en && PORT_SELECT_I == PORT_SER_STATUS |->
      BUS_READ_DATA_O == {6'h00, rx_full_reg, tx_ready})
    else $error("status read wrong");

  chk_rx_flag_clear: assert property ( // R11
    wr_en && PORT_SELECT_I == PORT_SER_STATUS && !rx_valid |=>
      !rx_full_reg)
    else $error("status write did not clear flag");

  chk_rx_flag_set: assert property ( // R10
    rx_valid |=> rx_full_reg)
    else $error("received byte did not set flag");

  chk_unmapped_zero: assert property ( // R16
    rd_en && (PORT_SELECT_I == 4'h5 || PORT_SELECT_I[3:2] == 2'b11) |->
      BUS_READ_DATA_O == 8'h00)
    else $error("unassigned port read not zero");

  chk_lamp_write: assert property ( // R14 R19
    wr_en && PORT_SELECT_I == PORT_LAMP_HI |=>
      LAMP_O[15:8] == $past(BUS_WRITE_DATA_I))
    else $error("lamp byte not written");
endmodule : gio_top

// ===== rtl/gio_uart.sv
// fixed rate full duplex serial engine
`timescale 1ns/1ns
module gio_uart #(
  parameter int CLK_DIV = 10416
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // transmit side
  input wire logic tx_start_i,
  input wire logic [7:0] tx_data_i,
  output logic tx_ready_o,
  output logic tx_pin_o,
  // receive side
  input wire logic rx_pin_i,
  output logic rx_valid_o,
  output logic [7:0] rx_data_o
);
  localparam int CW = $clog2(CLK_DIV);
  localparam logic [CW-1:0] FULL = CW'(CLK_DIV - 1);
  localparam logic [CW-1:0] HALF = CW'(CLK_DIV / 2);

  logic [9:0] tx_sh_reg, tx_sh_next;
  logic [3:0] tx_bits_reg, tx_bits_next;
  logic [CW-1:0] tx_cnt_reg, tx_cnt_next;
  logic rx_s1_reg, rx_s2_reg;
  logic [9:0] rx_sh_reg, rx_sh_next;
  logic [3:0] rx_bits_reg, rx_bits_next;
  logic [CW-1:0] rx_cnt_reg, rx_cnt_next;
  logic [7:0] rx_data_reg, rx_data_next;
  logic rx_valid_reg, rx_valid_next;

  // transmit: start, eight data, stop at one fixed rate
  always_comb begin
    tx_sh_next = tx_sh_reg;
    tx_bits_next = tx_bits_reg;
    tx_cnt_next = tx_cnt_reg;
    if (tx_bits_reg == 4'h0) begin
      if (tx_start_i) begin
        tx_sh_next = {1'b1, tx_data_i, 1'b0};
        tx_bits_next = 4'ha;
        tx_cnt_next = FULL; // R13
      end
    end else if (tx_cnt_reg == '0) begin
      tx_sh_next = {1'b1, tx_sh_reg[9:1]};
      tx_bits_next = tx_bits_reg - 4'h1;
      tx_cnt_next = FULL; // R13
    end else begin
      tx_cnt_next = tx_cnt_reg - 1'b1;
    end
  end

  // receive: sample mid-bit, check start and stop, R12
  always_comb begin
    rx_sh_next = rx_sh_reg;
    rx_bits_next = rx_bits_reg;
    rx_cnt_next = rx_cnt_reg;
    rx_data_next = rx_data_reg;
    rx_valid_next = 1'b0;
    if (rx_bits_reg == 4'h0) begin
      if (!rx_s2_reg) begin
        rx_bits_next = 4'ha;
        rx_cnt_next = HALF;
      end
    end else if (rx_cnt_reg == '0) begin
      rx_sh_next = {rx_s2_reg, rx_sh_reg[9:1]};
      rx_bits_next = rx_bits_reg - 4'h1;
      rx_cnt_next = FULL; // R13
      if (rx_bits_reg == 4'h1 && rx_s2_reg && !rx_sh_reg[1]) begin
        rx_data_next = rx_sh_reg[9:2];
        rx_valid_next = 1'b1;
      end
    end else begin
      rx_cnt_next = rx_cnt_reg - 1'b1;
    end
  end

  // state registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_sh_reg <= 10'h3ff;
      tx_bits_reg <= 4'h0;
      tx_cnt_reg <= '0;
      rx_s1_reg <= 1'b1;
      rx_s2_reg <= 1'b1;
      rx_sh_reg <= 10'h3ff;
      rx_bits_reg <= 4'h0;
      rx_cnt_reg <= '0;
      rx_data_reg <= 8'h00;
      rx_valid_reg <= 1'b0;
    end else begin
      tx_sh_reg <= tx_sh_next;
      tx_bits_reg <= tx_bits_next;
      tx_cnt_reg <= tx_cnt_next;
      rx_s1_reg <= rx_pin_i; // R12
      rx_s2_reg <= rx_s1_reg;
      rx_sh_reg <= rx_sh_next;
      rx_bits_reg <= rx_bits_next;
      rx_cnt_reg <= rx_cnt_next;
      rx_data_reg <= rx_data_next;
      rx_valid_reg <= rx_valid_next;
    end
  end

  assign tx_ready_o = (tx_bits_reg == 4'h0);
  assign tx_pin_o = tx_sh_reg[0];
  assign rx_valid_o = rx_valid_reg;
  assign rx_data_o = rx_data_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_tx_start_bit: assert property ( // R9
    tx_start_i && tx_ready_o |=> !tx_pin_o && !tx_ready_o)
    else $error("start bit not driven after transmit start");
endmodule : gio_uart

// ===== testbench/gio_cpu_model.sv
// cpu side bus master model for the game io peripherals
`timescale 1ns/1ns
module gio_cpu_model (
  // clock
  input wire logic clk_i,
  // peripheral bus toward the block
  output logic [gio_pkg::PORT_W-1:0] port_select_o,
  output logic bus_direction_o,
  output logic bus_transfer_strobe_o,
  output logic [gio_pkg::DATA_W-1:0] bus_write_data_o,
  input wire logic [gio_pkg::DATA_W-1:0] bus_read_data_i
);
  import gio_pkg::*;
  logic [DATA_W-1:0] read_data_reg;
  // ----------------
  // idle bus
  // ----------------
  initial begin
    port_select_o = 4'h0;
    bus_direction_o = 1'b0;
    bus_transfer_strobe_o = 1'b0;
    bus_write_data_o = 8'h00;
  end
  // read data taken at the transfer edge, before updates land
  always @(posedge clk_i) begin
    read_data_reg <= bus_read_data_i;
  end
  // ----------------
  // one transfer: raised after an edge, held to the next edge
  // ----------------
  task automatic transfer(input logic dir, input logic [PORT_W-1:0] port,
                          input logic [DATA_W-1:0] wdata,
                          output logic [DATA_W-1:0] rdata);
    @(posedge clk_i);
    port_select_o <= port;
    bus_direction_o <= dir;
    bus_write_data_o <= wdata;
    bus_transfer_strobe_o <= 1'b1;
    @(posedge clk_i);
    // released lines show the inverse of their last value
    bus_transfer_strobe_o <= 1'b0;
    port_select_o <= ~port;
    bus_direction_o <= ~dir;
    bus_write_data_o <= ~wdata;
    #1;
    rdata = read_data_reg;
  endtask : transfer
  // write one byte to a port
  task automatic bus_write(input logic [PORT_W-1:0] port,
                           input logic [DATA_W-1:0] data);
    logic [DATA_W-1:0] unused;
    transfer(1'b1, port, data, unused);
  endtask : bus_write
  // read one byte from a port
  task automatic bus_read(input logic [PORT_W-1:0] port,
                          output logic [DATA_W-1:0] data);
    transfer(1'b0, port, 8'h00, data);
  endtask : bus_read
endmodule : gio_cpu_model

// ===== testbench/test_game_io_peripherals.sv
// self-checking bench for the game io peripherals
`timescale 1ns/1ns
module test_game_io_peripherals;
  import gio_pkg::*;
  localparam int SIM_BAUD = 16;
  localparam int SIM_TICK = 2;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [PORT_W-1:0] port_sel;
  logic bus_dir;
  logic strobe;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic [AXES-1:0] axis = 4'hf;
  logic [BUTTONS-1:0] button_n = 4'h5;
  logic trigger;
  logic uart_rx = 1'b1;
  logic uart_tx;
  logic [LAMPS-1:0] lamp;
  logic [LAMPS-1:0] segment;
  int cyc = 0;
  int bad_count = 0;
  int samples_checked = 0;
  // ----------------
  // clock, cycle count and serial loopback
  // ----------------
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= rst ? 0 : cyc + 1;
    uart_rx <= uart_tx;
  end
  // block under test and bus master
  gio_top #(.BAUD_DIV(SIM_BAUD), .TICK_CLKS(SIM_TICK)) DUT (
    .REF_CLK_I(ref_clk), .RST_I(rst), .PORT_SELECT_I(port_sel),
    .BUS_DIRECTION_I(bus_dir), .BUS_TRANSFER_STROBE_I(strobe),
    .BUS_WRITE_DATA_I(wdata), .BUS_READ_DATA_O(rdata),
    .STICK_AXIS_I(axis), .STICK_BUTTON_N_I(button_n),
    .STICK_TRIGGER_O(trigger), .UART_RX_I(uart_rx), .UART_TX_O(uart_tx),
    .LAMP_O(lamp), .SEGMENT_O(segment)
  );
  gio_cpu_model cpu (
    .clk_i(ref_clk), .port_select_o(port_sel), .bus_direction_o(bus_dir),
    .bus_transfer_strobe_o(strobe), .bus_write_data_o(wdata),
    .bus_read_data_i(rdata)
  );
  // ----------------
  // compare tasks and verdict
  // ----------------
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp,
                            input string what);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s: got %h want %h", $time, what, got, exp);
    end
  endtask : check_byte
  task automatic check_word(input logic [15:0] got, input logic [15:0] exp,
                            input string what);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s: got %h want %h", $time, what, got, exp);
    end
  endtask : check_word
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict
  // read a port and compare the byte
  task automatic rd(input logic [3:0] port, input logic [7:0] exp,
                    input string what);
    logic [7:0] d;
    cpu.bus_read(port, d);
    check_byte(d, exp, what);
  endtask : rd
  // poll the status port until it shows the wanted value
  task automatic wait_status(input logic [7:0] exp);
    logic [7:0] d;
    int k;
    d = 8'h00;
    for (k = 0; k < 300 && d !== exp; k++) begin
      cpu.bus_read(PORT_SER_STATUS, d);
    end
    if (d !== exp) begin
      bad_count++;
      $display("[FAIL] %0t status wait ran out", $time);
      print_verdict();
    end
  endtask : wait_status
  // ----------------
  // main sequence
  // ----------------
  initial begin
    int i;
    int n;
    int fall_tick[4];
    int quiet_port[10];
    fall_tick = '{1216, 1344, 1472, 1600};
    quiet_port = '{0, 1, 2, 3, 4, 5, 12, 13, 14, 15};
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    #1;
    // reset values
    check_word(lamp, LAMP_RST, "lamp reset");
    check_word(segment, SEG_RST, "segment reset");
    check_byte({7'h00, uart_tx}, 8'h01, "tx idle");
    check_byte(rdata, 8'h00, "read data idle");
    rd(PORT_SER_STATUS, 8'h01, "status reset");
    rd(PORT_BUTTONS, {4'h0, BUTTON_RST}, "buttons");
    for (i = 0; i < 4; i++) rd(4'(i), 8'h00, "axis reset");
    $display("test reset values done");
    // lamp and segment bytes, quiet ports
    cpu.bus_write(PORT_LAMP_LO, 8'h12);
    cpu.bus_write(PORT_LAMP_HI, 8'h34);
    cpu.bus_write(PORT_SEG_LO, 8'h56);
    cpu.bus_write(PORT_SEG_HI, 8'h78);
    check_word(lamp, 16'h3412, "lamps");
    check_word(segment, 16'h7856, "segments");
    for (i = 0; i < 10; i++) cpu.bus_write(4'(quiet_port[i]), 8'hff);
    check_word(lamp, 16'h3412, "lamps kept");
    check_word(segment, 16'h7856, "segments kept");
    rd(PORT_SER_STATUS, 8'h01, "status kept");
    rd(4'h5, 8'h00, "port 5");
    for (i = 8; i < 16; i++) rd(4'(i), 8'h00, "write only");
    $display("test lamps and quiet ports done");
    // serial loopback: start bit width, busy drop, flag clear
    cpu.bus_write(PORT_SER_DATA, 8'ha5);
    n = 0;
    while (uart_tx === 1'b0 && n < 4 * SIM_BAUD) begin
      n++;
      @(posedge ref_clk);
      #1;
    end
    check_word(16'(n), 16'(SIM_BAUD), "start bit");
    rd(PORT_SER_STATUS, 8'h00, "status busy");
    cpu.bus_write(PORT_SER_DATA, 8'h3c);
    wait_status(8'h03);
    rd(PORT_SER_DATA, 8'ha5, "rx byte");
    repeat (15 * SIM_BAUD) @(posedge ref_clk);
    rd(PORT_SER_DATA, 8'ha5, "busy byte dropped");
    rd(PORT_SER_STATUS, 8'h03, "status full");
    cpu.bus_write(PORT_SER_STATUS, 8'h5a);
    rd(PORT_SER_STATUS, 8'h01, "flag cleared");
    $display("test serial done");
    // axes fall at known tick counts
    for (i = 0; i < 4; i++) begin
      for (n = 0; n < 100000 && cyc < fall_tick[i] * SIM_TICK; n++) begin
        @(posedge ref_clk);
      end
      axis[i] <= 1'b0;
    end
    repeat (10) @(posedge ref_clk);
    for (i = 0; i < 4; i++) rd(4'(i), 8'(i + 9), "axis count");
    check_byte({7'h00, trigger}, 8'h00, "no trigger");
    rd(PORT_BUTTONS, 8'h0f, "buttons unlatched");
    // counter wraps: buttons latched, trigger for one tick
    for (n = 0; n < 70000 && trigger !== 1'b1; n++) begin
      @(posedge ref_clk);
      #1;
    end
    check_byte({7'h00, trigger}, 8'h01, "rollover trigger");
    rd(PORT_BUTTONS, 8'h05, "buttons latched");
    check_byte({7'h00, trigger}, 8'h00, "trigger ended");
    $display("test axes done");
    print_verdict();
  end
endmodule : test_game_io_peripherals
